/* File: channel_sense.sv */
// One request pin: synchroniser, filtered level and edge detector
`timescale 1ns/100ps
`default_nettype none
module channel_sense
    import ext_irq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       pin,
    input  wire logic [1:0] sense,
    input  wire logic       io_run,
    output logic            level,
    output logic            edge_hit
);
    chan_state_t r;
    chan_state_t n;

    // A change counts only once the second and third stages agree
    always_comb begin
        n = r;
        n.sync = {r.sync[1:0], pin};
        if (r.sync[2] == r.sync[1]) begin
            n.filt = r.sync[2];
        end
        n.prev = r.filt;
        // Without the I/O clock no edge is seen at all
        case (sense)
            SENSE_ANY:  n.edge_hit = io_run & (r.filt ^ r.prev);
            SENSE_FALL: n.edge_hit = io_run & r.prev & ~r.filt;
            SENSE_RISE: n.edge_hit = io_run & ~r.prev & r.filt;
            default:    n.edge_hit = 1'b0;
        endcase
    end

    // Pins idle high so the filter starts out high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= CHAN_RST;
        end else begin
            r <= n;
        end
    end

    assign level    = r.filt;
    assign edge_hit = r.edge_hit;

    filt_agree_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.sync[2] == r.sync[1]) |=> (r.filt == $past(r.sync[2])))
        else $error("filtered level missed an agreed sample");
    pulse_caught_a: assert property (@(posedge clk) disable iff (!nrst)
        (io_run && sense == SENSE_FALL && $fell(r.filt)) |=> edge_hit)
        else $error("falling edge not reported");
endmodule
`default_nettype wire

/* File: ext_irq_pkg.sv */
// Constants, types and reset values shared by the external pin interrupt logic
package ext_irq_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int WDT_PERIOD_NS = 1000;    // Nominal watchdog oscillator period

    // Start-up delays picked by the fuses, least times rounded up
    localparam int SUT0_NS = 4000;
    localparam int SUT1_NS = 16000;
    localparam int SUT2_NS = 32000;
    localparam int SUT3_NS = 64000;
    localparam int DLY_W   = 11;
    localparam logic [DLY_W-1:0] SUT0_CYC = DLY_W'((SUT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DLY_W-1:0] SUT1_CYC = DLY_W'((SUT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DLY_W-1:0] SUT2_CYC = DLY_W'((SUT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DLY_W-1:0] SUT3_CYC = DLY_W'((SUT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register byte addresses
    localparam logic [7:0] SENSE_ADR = 8'h00;
    localparam logic [7:0] MASK_ADR  = 8'h04;
    localparam logic [7:0] FLAG_ADR  = 8'h08;
    localparam logic [7:0] CTRL_ADR  = 8'h0c;
    localparam logic [7:0] STAT_ADR  = 8'h10;

    // Control register fields
    localparam int CTRL_GIE_BIT  = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam logic [1:0] MODE_ACTIVE  = 2'h0;
    localparam logic [1:0] MODE_IDLE    = 2'h1;
    localparam logic [1:0] MODE_PDOWN   = 2'h2;
    localparam logic [1:0] MODE_STANDBY = 2'h3;

    // Sense select codes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_ANY  = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    typedef enum logic [2:0] {
        ST_RUN    = 3'h1,
        ST_SAMPLE = 3'h2,
        ST_START  = 3'h4
    } wake_state_t;

    typedef struct packed {
        logic [2:0] sync;
        logic       filt;
        logic       prev;
        logic       edge_hit;
    } chan_state_t;

    typedef struct packed {
        logic [7:0]       sense;
        logic [3:0]       mask;
        logic [3:0]       flags;
        logic             gie;
        logic [1:0]       mode;
        wake_state_t      st;
        logic             lowcnt;
        logic [DLY_W-1:0] dly;
        logic [2:0]       wdt_sync;
        logic             wdt_filt;
        logic             wdt_prev;
        logic             ack;
        logic [31:0]      dat;
        logic [3:0]       irq;
        logic             wake;
    } core_state_t;

    localparam chan_state_t CHAN_RST = '{sync: 3'h7, filt: 1'b1, prev: 1'b1, edge_hit: 1'b0};
    localparam core_state_t CORE_RST = '{sense: 8'h00, mask: 4'h0, flags: 4'h0, gie: 1'b0,
        mode: MODE_ACTIVE, st: ST_RUN, lowcnt: 1'b0, dly: '0, wdt_sync: 3'h0, wdt_filt: 1'b0,
        wdt_prev: 1'b0, ack: 1'b0, dat: 32'h0000_0000, irq: 4'h0, wake: 1'b0};
endpackage

/* File: external_pin_interrupts.sv */
// Four-channel external pin interrupt logic with Wishbone registers and wake-up qualifier
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupts
    import ext_irq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [3:0]  ext_irq_pins,
    input  wire logic [3:0]  pin_drive_en,
    input  wire logic [3:0]  pin_drive_val,
    input  wire logic        wdt_osc,
    input  wire logic [1:0]  startup_time_fuses,
    input  wire logic [3:0]  irq_ack,
    output logic [3:0]       irq_req,
    output logic             wake_req
);
    core_state_t      r;
    core_state_t      n;
    logic [3:0]       pad;
    logic [3:0]       level;
    logic [3:0]       hit;
    logic [3:0]       lvl_mask;
    logic [3:0]       enabled;
    logic [3:0]       set_v;
    logic [3:0]       clr_v;
    logic             io_run;
    logic             sleeping;
    logic             tick;
    logic             lvl_arm;
    logic             req;
    logic             wr;
    logic [DLY_W-1:0] sut_cyc;

    // A driven pin is seen at its driven value, so software can raise requests
    assign pad = (pin_drive_en & pin_drive_val) | (~pin_drive_en & ext_irq_pins);

    // I/O clock runs only when awake or in Idle
    assign io_run   = (r.mode == MODE_ACTIVE) || (r.mode == MODE_IDLE);
    assign sleeping = ~io_run;

    // One detector per request pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            channel_sense u_chan (
                .clk      (clk),
                .nrst     (nrst),
                .pin      (pad[gi]),
                .sense    (r.sense[2*gi +: 2]),
                .io_run   (io_run),
                .level    (level[gi]),
                .edge_hit (hit[gi])
            );
            assign lvl_mask[gi] = (r.sense[2*gi +: 2] == SENSE_LOW);
        end
    endgenerate

    // Start-up delay chosen by the fuses
    always_comb begin
        case (startup_time_fuses)
            2'h0:    sut_cyc = SUT0_CYC;
            2'h1:    sut_cyc = SUT1_CYC;
            2'h2:    sut_cyc = SUT2_CYC;
            default: sut_cyc = SUT3_CYC;
        endcase
    end

    // Whole next state
    always_comb begin
        n        = r;
        req      = cyc_i & stb_i & ~r.ack;
        wr       = req & we_i & sel_i[0];
        enabled  = r.mask & {4{r.gie}};
        lvl_arm  = |(enabled & lvl_mask & ~level);
        n.ack    = req;
        n.wake   = 1'b0;

        // Watchdog oscillator is another clock: three stages, agreement filter
        n.wdt_sync = {r.wdt_sync[1:0], wdt_osc};
        if (r.wdt_sync[2] == r.wdt_sync[1]) begin
            n.wdt_filt = r.wdt_sync[2];
        end
        n.wdt_prev = r.wdt_filt;
        tick       = r.wdt_filt & ~r.wdt_prev;

        // Register writes take effect at the edge that raises ack
        clr_v = irq_ack;
        if (wr) begin
            case (adr_i)
                SENSE_ADR: n.sense = dat_i[7:0];
                MASK_ADR:  n.mask  = dat_i[3:0];
                FLAG_ADR:  clr_v   = irq_ack | dat_i[3:0];
                CTRL_ADR: begin
                    n.gie  = dat_i[CTRL_GIE_BIT];
                    n.mode = dat_i[CTRL_MODE_LSB +: 2];
                end
                default: ;
            endcase
        end

        // Set beats clear; flags stay clear while a channel senses level
        set_v   = hit & ~lvl_mask;
        n.flags = ((r.flags & ~clr_v) | set_v) & ~lvl_mask;

        // Wake qualifier runs on clk alone, never on the halted I/O clock
        case (r.st)
            ST_RUN: begin
                n.lowcnt = 1'b0;
                if (sleeping) begin
                    n.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (!sleeping) begin
                    n.st = ST_RUN;
                end else if (tick) begin
                    if (lvl_arm && r.lowcnt) begin
                        n.st  = ST_START;
                        n.dly = sut_cyc;
                    end else begin
                        n.lowcnt = lvl_arm;
                    end
                end
            end
            ST_START: begin
                // Wake completes even if the level has gone meanwhile
                if (r.dly <= DLY_W'(1)) begin
                    n.st   = ST_RUN;
                    n.mode = MODE_ACTIVE;
                    n.wake = 1'b1;
                end else begin
                    n.dly = r.dly - DLY_W'(1);
                end
            end
            default: n.st = ST_RUN;
        endcase

        // Level requests only while the I/O clock runs (Active or Idle), so a vanished level raises nothing
        for (int i = 0; i < 4; i++) begin
            if (lvl_mask[i]) begin
                n.irq[i] = enabled[i] & ~level[i] & io_run;
            end else begin
                n.irq[i] = enabled[i] & r.flags[i];
            end
        end

        // Read data is captured with ack; unmapped words read zero
        if (req && !we_i) begin
            case (adr_i)
                SENSE_ADR: n.dat = {24'h0, r.sense};
                MASK_ADR:  n.dat = {28'h0, r.mask};
                FLAG_ADR:  n.dat = {28'h0, r.flags};
                CTRL_ADR:  n.dat = {29'h0, r.mode, r.gie};
                STAT_ADR:  n.dat = {24'h0, 1'b0, r.st, level};
                default:   n.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    assign dat_o    = r.dat;
    assign ack_o    = r.ack;
    assign irq_req  = r.irq;
    assign wake_req = r.wake;

    // Checks next to the logic they guard
    ack_single_a: assert property (@(posedge clk) disable iff (!nrst)
        r.ack |=> !r.ack)
        else $error("ack held longer than one cycle");
    flag_level_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 ((r.flags & $past(lvl_mask)) == 4'h0))
        else $error("flag set on a level-sensed channel");
    flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (|set_v) |=> ((r.flags & $past(set_v)) == $past(set_v)))
        else $error("detected edge did not set its flag");
    irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        !r.gie |=> (r.irq == 4'h0))
        else $error("request passed with global enable off");
    level_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (lvl_mask[3] && enabled[3] && !level[3] && io_run) [*3] |=> r.irq[3])
        else $error("held low level stopped requesting");
    asleep_edge_a: assert property (@(posedge clk) disable iff (!nrst)
        (sleeping ##1 sleeping) |=> ((r.flags & ~$past(r.flags)) == 4'h0))
        else $error("edge flag set with I/O clock stopped");
    two_samples_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.st == ST_SAMPLE && !(tick && r.lowcnt)) |=> (r.st != ST_START))
        else $error("start-up began without two low samples");
    // The load bounds the count and every cycle must shrink it, so wake comes in time
    wake_load_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(r.st == ST_START) |-> (r.dly == $past(sut_cyc)))
        else $error("start-up count not loaded from the fuses");
    wake_end_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.st == ST_START) |=> (r.wake || (r.st == ST_START && r.dly < $past(r.dly))))
        else $error("wake did not follow the start-up delay");
    wake_mode_a: assert property (@(posedge clk) disable iff (!nrst)
        r.wake |-> (r.mode == MODE_ACTIVE && $past(r.st) == ST_START))
        else $error("wake pulse without active mode");

    wake_cov: cover property (@(posedge clk) disable iff (!nrst) r.wake);
    flag_cov: cover property (@(posedge clk) disable iff (!nrst) |set_v);
    level_cov: cover property (@(posedge clk) disable iff (!nrst) |(r.irq & lvl_mask));
endmodule
`default_nettype wire

/* File: external_pin_interrupts_tb_top.sv */
// Testbench: register-level checks of the external pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupts_tb_top;
    import ext_irq_pkg::*;
    logic        clk     = 1'b0;
    logic        nrst    = 1'b0;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [3:0]  lanes;
    logic [3:0]  drv_en;
    logic [3:0]  drv_val;
    logic [3:0]  ack;
    logic [1:0]  fuse;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        wake;
    logic        wdt;
    logic        seen;
    logic [3:0]  pins;
    logic [3:0]  irq;
    int          bad_count = 0;
    int          compares  = 0;
    int          n;
    int          dly[4] = '{100, 400, 800, 1600};

    external_pin_interrupts external_pin_interrupts_inst (.clk(clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .ext_irq_pins(pins),
        .pin_drive_en(drv_en), .pin_drive_val(drv_val), .wdt_osc(wdt), .startup_time_fuses(fuse),
        .irq_ack(ack), .irq_req(irq), .wake_req(wake));
    pin_source_model pin_source_model_inst (.clk(clk), .irq_req(irq), .pins(pins), .wdt_osc(wdt));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic close_out;
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic Wishbone cycle: request held until ack is sampled, one idle cycle after
    // No cycle count is assumed; only the hang guard ends a wait for ack
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= lanes;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Ack is a one-cycle pulse, so it must be gone at the idle edge
        @(posedge clk);
        chk({31'h0, ack_o}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Hang guard sized well above the longest start-up sweep
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        cyc     <= 1'b0;
        stb     <= 1'b0;
        we      <= 1'b0;
        adr     <= 8'h00;
        wdat    <= 32'h0;
        sel     <= 4'hf;
        drv_en  <= 4'h0;
        drv_val <= 4'h0;
        ack     <= 4'h0;
        fuse    <= 2'h0;
        lanes    = 4'hf;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(SENSE_ADR, 32'h0);
        rd(MASK_ADR, 32'h0);
        rd(CTRL_ADR, 32'h0);
        rd(8'h14, 32'h0);
        rd(STAT_ADR, 32'h1f);
        // A write with byte lane 0 off is ignored
        lanes = 4'he;
        xfer(1'b1, MASK_ADR, 32'hf);
        lanes = 4'hf;
        rd(MASK_ADR, 32'h0);
        // ch0 falling, ch1 rising, ch2 any change, ch3 low; sense set with mask off
        xfer(1'b1, SENSE_ADR, 32'h1e);
        xfer(1'b1, MASK_ADR, 32'hf);
        xfer(1'b1, CTRL_ADR, 32'h1);
        // Two-cycle low pulse is the shortest one that must be caught
        pin_source_model_inst.set(4'h0);
        wt(1);
        pin_source_model_inst.set(4'hf);
        wt(8);
        chk({28'h0, irq}, 32'h7);
        rd(FLAG_ADR, 32'h7);
        xfer(1'b1, FLAG_ADR, 32'h3);
        rd(FLAG_ADR, 32'h4);
        @(posedge clk) ack <= 4'h4;
        @(posedge clk) ack <= 4'h0;
        rd(FLAG_ADR, 32'h0);
        // Level channel requests for as long as held, flag stays clear
        pin_source_model_inst.set(4'h7);
        wt(30);
        chk({28'h0, irq}, 32'h8);
        rd(FLAG_ADR, 32'h0);
        xfer(1'b1, MASK_ADR, 32'h7);
        wt(2);
        chk({28'h0, irq}, 32'h0);
        xfer(1'b1, MASK_ADR, 32'hf);
        xfer(1'b1, CTRL_ADR, 32'h0);
        wt(2);
        chk({28'h0, irq}, 32'h0);
        pin_source_model_inst.set(4'hf);
        xfer(1'b1, CTRL_ADR, 32'h1);
        // Pin driven as an output still raises its request
        @(posedge clk) drv_en <= 4'h2;
        wt(6);
        @(posedge clk) drv_val <= 4'h2;
        wt(8);
        rd(FLAG_ADR, 32'h2);
        @(posedge clk) drv_en <= 4'h0;
        xfer(1'b1, FLAG_ADR, 32'hf);
        // Edges seen in Idle only; power-down and standby stop the I/O clock
        for (int m = 1; m < 4; m++) begin
            xfer(1'b1, CTRL_ADR, 32'(m * 2 + 1));
            pin_source_model_inst.set(4'he);
            wt(1);
            pin_source_model_inst.set(4'hf);
            wt(8);
            rd(FLAG_ADR, (m == 1) ? 32'h1 : 32'h0);
            xfer(1'b1, FLAG_ADR, 32'hf);
        end
        // Power-down wake for every start-up choice; last one drops the level early
        xfer(1'b1, CTRL_ADR, 32'h1);
        xfer(1'b1, MASK_ADR, 32'h8);
        for (int f = 0; f < 4; f++) begin
            @(posedge clk) fuse <= 2'(f);
            xfer(1'b1, CTRL_ADR, 32'h5);
            pin_source_model_inst.hold_low(3);
            n = 0;
            do begin
                @(posedge clk);
                n++;
                // Both samples are taken by now: start-up runs, then the level goes
                if (f == 3 && n == 80) begin
                    rd(STAT_ADR, 32'h47);
                    pin_source_model_inst.set(4'hf);
                end
            end while (wake !== 1'b1 && n < 2500);
            chk(32'(n >= dly[f] && n <= dly[f] + 90), 32'h1);
            seen = 1'b0;
            repeat (10) begin
                @(posedge clk);
                seen = seen | irq[3];
            end
            chk({31'h0, seen}, (f == 3) ? 32'h0 : 32'h1);
            rd(CTRL_ADR, 32'h1);
            pin_source_model_inst.set(4'hf);
            wt(8);
        end
        close_out();
    end
endmodule
`default_nettype wire

/* File: pin_source_model.sv */
// Partner model: external request sources and the watchdog oscillator
`timescale 1ns/100ps
`default_nettype none
module pin_source_model (
    input  wire logic       clk,
    input  wire logic [3:0] irq_req,
    output logic      [3:0] pins,
    output logic            wdt_osc
);
    logic [3:0] hold_r;

    // Pins idle high as if pulled up; oscillator starts low
    initial begin
        pins    = 4'hf;
        hold_r  = 4'h0;
        wdt_osc = 1'b0;
    end

    // Free-running oscillator at its nominal 1 us period, unrelated to clk
    always #500 wdt_osc = ~wdt_osc;

    // A held low stays until its request reaches the core, so sleep wake-up cannot lose it
    always @(posedge clk) begin
        if ((irq_req & hold_r) != 4'h0) begin
            pins   <= pins | (irq_req & hold_r);
            hold_r <= hold_r & ~irq_req;
        end
    end

    // Plain levels on all pins, nothing held
    task automatic set(input logic [3:0] v);
        @(posedge clk);
        pins   <= v;
        hold_r <= 4'h0;
    endtask

    // Low level kept until the request is taken
    task automatic hold_low(input int idx);
        @(posedge clk);
        pins[idx]   <= 1'b0;
        hold_r[idx] <= 1'b1;
    endtask
endmodule
`default_nettype wire
